// [uirq_map.svh]
// register offsets, field positions and reset values of the usb interrupt wrapper
`ifndef UIRQ_MAP_SVH
`define UIRQ_MAP_SVH

// ==========================================================
// byte offsets on the register bus
`define UIRQ_OFS_CTRL      6'h00
`define UIRQ_OFS_SRC       6'h20
`define UIRQ_OFS_SRC_SET   6'h24
`define UIRQ_OFS_SRC_CLR   6'h28
`define UIRQ_OFS_MSK       6'h2C
`define UIRQ_OFS_MSK_SET   6'h30
`define UIRQ_OFS_MSK_CLR   6'h34
`define UIRQ_OFS_MASKED    6'h38

// ==========================================================
// field positions
`define UIRQ_CORE_MSB      24
`define UIRQ_CORE_LSB      16
`define UIRQ_VBUS_BIT      24
`define UIRQ_RX_MSB        12
`define UIRQ_RX_LSB        9
`define UIRQ_TX_MSB        4
`define UIRQ_TX_LSB        1
`define UIRQ_EP0_BIT       0
`define UIRQ_SEL_BIT       0

// ==========================================================
// implemented bits and reset values
`define UIRQ_VALID         32'h01FF1E1F
`define UIRQ_SRC_RST       32'h00000000
`define UIRQ_MSK_RST       32'h00000000
`define UIRQ_CTRL_RST      32'h00000000

`endif

// [uirq_pkg.sv]
// types shared by the usb interrupt wrapper modules
package uirq_pkg;

   typedef logic [31:0] uirq_word_t;

   typedef enum logic [1:0] {
      UIRQ_ST_IDLE = 2'b01,
      UIRQ_ST_ACK  = 2'b10
   } uirq_bus_e;

endpackage

// [uirq_if.sv]
// carrier between the register front end and the two bit banks
interface uirq_if (
   input wire logic clk,
   input wire logic rstn
);
   import uirq_pkg::*;

   uirq_word_t src_set;
   uirq_word_t src_clr;
   uirq_word_t msk_set;
   uirq_word_t msk_clr;
   uirq_word_t src;
   uirq_word_t msk;

   modport regs     (input clk, input rstn, output src_set, output src_clr,
                     output msk_set, output msk_clr, input src, input msk);
   modport src_bank (input clk, input rstn, input src_set, input src_clr, output src);
   modport msk_bank (input clk, input rstn, input msk_set, input msk_clr, output msk);
endinterface

// [uirq_src_bank.sv]
// sticky interrupt source bits, set by hardware or software, cleared by software
`include "uirq_map.svh"

module uirq_src_bank
   import uirq_pkg::*;
(
   uirq_if.src_bank bus
);

   uirq_word_t src_q;

   // ==========================================================
   // one flop per implemented bit
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         localparam uirq_word_t VALID = `UIRQ_VALID;
         if (VALID[i]) begin : g_imp
            logic bit_q;
            // a set in the clearing cycle wins
            always_ff @(posedge bus.clk) begin
               if (!bus.rstn) begin
                  bit_q <= 1'b0;
               end else if (bus.src_set[i]) begin
                  bit_q <= 1'b1;
               end else if (bus.src_clr[i]) begin
                  bit_q <= 1'b0;
               end
            end
            // one driver kind per bit of the word
            assign src_q[i] = bit_q;
         end else begin : g_rsv
            assign src_q[i] = 1'b0;
         end
      end
   endgenerate

   assign bus.src = src_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge bus.clk); endclocking
   default disable iff (!bus.rstn);

   a_rsv_src_zero: assert property ((src_q & ~`UIRQ_VALID) == 32'h00000000)
      else $error("reserved source bit set");
   a_set_sticky: assert property ((|(bus.src_set & `UIRQ_VALID)) |=>
      ((src_q & $past(bus.src_set & `UIRQ_VALID)) == $past(bus.src_set & `UIRQ_VALID)))
      else $error("source set lost");

endmodule

// [uirq_msk_bank.sv]
// mask bits, changed only by the set and clear strobes
`include "uirq_map.svh"

module uirq_msk_bank
   import uirq_pkg::*;
(
   uirq_if.msk_bank bus
);

   uirq_word_t msk_q;

   // ==========================================================
   // one flop per implemented bit, same position as its source
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         localparam uirq_word_t VALID = `UIRQ_VALID;
         if (VALID[i]) begin : g_imp
            logic bit_q;
            always_ff @(posedge bus.clk) begin
               if (!bus.rstn) begin
                  bit_q <= 1'b0;
               end else if (bus.msk_set[i]) begin
                  bit_q <= 1'b1;
               end else if (bus.msk_clr[i]) begin
                  bit_q <= 1'b0;
               end
            end
            assign msk_q[i] = bit_q;
         end else begin : g_rsv
            assign msk_q[i] = 1'b0;
         end
      end
   endgenerate

   assign bus.msk = msk_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge bus.clk); endclocking
   default disable iff (!bus.rstn);

   a_msk_quiet: assert property ((bus.msk_set == 32'h00000000 && bus.msk_clr == 32'h00000000)
      |=> $stable(msk_q))
      else $error("mask changed without strobe");

endmodule

// [uirq_top.sv]
// usb interrupt acknowledge and mask wrapper behind an avalon-mm slave
//
// Operation
// - one clears matching core event source
// - one clears matching receive endpoint source
// - one clears matching transmit endpoint source
// - bit zero one clears control endpoint
// - masks never touch raw source bits
// - mask bits align with source bits
// - mask fields: core, rx, tx, ep0
// - mask register ignores direct writes
// - one sets core event mask bit
// - mask set read returns mask register
// - endpoint mask set ones enable individually
// - core bits 23-16 general, 24 power
// - source clear read returns source register
// - mask clear ones disable mask bits
// - masked status is source and mask
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`include "uirq_map.svh"

module uirq_top
   import uirq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [7:0]  core_general_irq,
   input  wire logic        bus_power_drive_irq,
   input  wire logic [3:0]  rx_endpoint_irq,
   input  wire logic [3:0]  tx_endpoint_irq,
   input  wire logic        control_endpoint_irq,
   output logic             core_irq_select,
   output logic             irq
);

   // ==========================================================
   // declarations
   uirq_if bus (.clk(clk), .rstn(rstn));

   uirq_bus_e  state_q;
   logic       wait_q;
   uirq_word_t rdata_q;
   uirq_word_t ctrl_q;
   logic       irq_q;

   logic       req;
   logic       commit_wr;
   uirq_word_t lane_mask;
   uirq_word_t wdata_m;
   uirq_word_t hw_set;
   uirq_word_t masked;
   uirq_word_t rd_mux;

   // ==========================================================
   // bit banks
   uirq_src_bank u_src (
      .bus (bus.src_bank)
   );

   uirq_msk_bank u_msk (
      .bus (bus.msk_bank)
   );

   // ==========================================================
   // hardware event mapping
   // bit 24 power drive, 23..16 general core events
   assign hw_set = {7'h00,
                    bus_power_drive_irq,
                    core_general_irq,
                    3'h0,
                    rx_endpoint_irq,
                    4'h0,
                    tx_endpoint_irq,
                    control_endpoint_irq};

   // ==========================================================
   // bus handshake: one wait state on every access
   assign req = avs_read | avs_write;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= UIRQ_ST_IDLE;
      end else begin
         case (state_q)
            UIRQ_ST_IDLE: begin
               if (req) begin
                  state_q <= UIRQ_ST_ACK;
               end
            end
            UIRQ_ST_ACK: begin
               state_q <= UIRQ_ST_IDLE;
            end
            default: begin
               state_q <= UIRQ_ST_IDLE;
            end
         endcase
      end
   end

   // waitrequest drops for exactly the cycle that ends the access
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !(state_q == UIRQ_ST_IDLE && req);
      end
   end

   // writes land only on the edge the master sees waitrequest low
   assign commit_wr = (state_q == UIRQ_ST_ACK) && avs_write;

   assign lane_mask = {{8{avs_byteenable[3]}},
                       {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}},
                       {8{avs_byteenable[0]}}};

   assign wdata_m = avs_writedata & lane_mask & `UIRQ_VALID;

   // ==========================================================
   // strobes into the banks
   always_comb begin
      bus.src_set = hw_set;
      bus.src_clr = 32'h00000000;
      bus.msk_set = 32'h00000000;
      bus.msk_clr = 32'h00000000;
      if (commit_wr) begin
         case (avs_address)
            `UIRQ_OFS_SRC_SET: begin
               bus.src_set = hw_set | wdata_m;
            end
            `UIRQ_OFS_SRC_CLR: begin
               bus.src_clr = wdata_m;
            end
            `UIRQ_OFS_MSK_SET: begin
               bus.msk_set = wdata_m;
            end
            `UIRQ_OFS_MSK_CLR: begin
               bus.msk_clr = wdata_m;
            end
            default: begin
               // plain mask register write is dropped
               bus.msk_set = 32'h00000000;
            end
         endcase
      end
   end

   // ==========================================================
   // control register
   // endpoint fields stay live either way; the select only drives core_irq_select and its readback
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= `UIRQ_CTRL_RST;
      end else if (commit_wr && avs_address == `UIRQ_OFS_CTRL && avs_byteenable[0]) begin
         ctrl_q <= {31'h00000000, avs_writedata[`UIRQ_SEL_BIT]};
      end
   end

   // ==========================================================
   // read path
   assign masked = bus.src & bus.msk;

   always_comb begin
      case (avs_address)
         `UIRQ_OFS_CTRL:    rd_mux = ctrl_q;
         `UIRQ_OFS_SRC:     rd_mux = bus.src;
         `UIRQ_OFS_SRC_SET: rd_mux = bus.src;
         `UIRQ_OFS_SRC_CLR: rd_mux = bus.src;
         `UIRQ_OFS_MSK:     rd_mux = bus.msk;
         `UIRQ_OFS_MSK_SET: rd_mux = bus.msk;
         `UIRQ_OFS_MSK_CLR: rd_mux = bus.msk;
         `UIRQ_OFS_MASKED:  rd_mux = masked;
         default:           rd_mux = 32'h00000000;
      endcase
   end

   // data is captured one cycle early; no write can change it before the ack
   // edge because writes only commit there
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 32'h00000000;
      end else if (state_q == UIRQ_ST_IDLE && avs_read) begin
         rdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // interrupt output
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |masked;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign core_irq_select = ctrl_q[`UIRQ_SEL_BIT];
   assign irq             = irq_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   localparam uirq_word_t VALID = `UIRQ_VALID;

   sequence s_clr_wr;
      commit_wr && avs_address == `UIRQ_OFS_SRC_CLR;
   endsequence

   sequence s_mset_wr;
      commit_wr && avs_address == `UIRQ_OFS_MSK_SET;
   endsequence

   a_wait_one: assert property ((state_q == UIRQ_ST_IDLE && req) |=> !avs_waitrequest ##1
      avs_waitrequest)
      else $error("waitrequest did not pulse low for one cycle");

   a_src_cleared: assert property (s_clr_wr |=>
      ((bus.src & $past(wdata_m & ~hw_set)) == 32'h00000000))
      else $error("source bit not cleared");

   a_zero_keeps: assert property (s_clr_wr |=>
      (($past(bus.src) & ~$past(wdata_m) & ~bus.src) == 32'h00000000))
      else $error("source cleared by zero");

   a_mask_ro: assert property ((commit_wr && avs_address == `UIRQ_OFS_MSK) |=>
      $stable(bus.msk))
      else $error("mask changed by direct write");

   a_mask_set: assert property (s_mset_wr |=>
      ((bus.msk & $past(wdata_m)) == $past(wdata_m)) && (($past(bus.msk) & ~bus.msk) == 0))
      else $error("mask set wrong");

   a_mask_clr: assert property ((commit_wr && avs_address == `UIRQ_OFS_MSK_CLR) |=>
      ((bus.msk & $past(wdata_m)) == 32'h00000000) && $past(bus.msk_set) == 32'h00000000)
      else $error("mask clear wrong");

   a_mset_rdback: assert property ((state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_MSK_SET) |-> avs_readdata == bus.msk)
      else $error("mask set read mismatch");

   a_clr_rdback: assert property ((state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_SRC_CLR) |-> avs_readdata == $past(bus.src))
      else $error("source clear read mismatch");

   a_masked_read: assert property ((state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_MASKED) |-> avs_readdata == ($past(bus.src) & $past(bus.msk)))
      else $error("masked read mismatch");

   a_raw_unmasked: assert property ((|(hw_set & ~bus.msk)) |=>
      (bus.src & $past(hw_set)) == $past(hw_set))
      else $error("masked source was not latched");

   a_irq_level: assert property ((|(bus.src & bus.msk)) |=> irq)
      else $error("interrupt missing");

   a_irq_quiet: assert property (((bus.src & bus.msk) == 32'h00000000) |=> !irq)
      else $error("spurious interrupt");

   a_rsv_read: assert property (!avs_waitrequest |-> (avs_readdata & ~VALID & ~32'h1) == 0)
      else $error("reserved bits read nonzero");

   // ==========================================================
   // handshake shape and register side effects

   a_ack_only: assert property (!avs_waitrequest |-> state_q == UIRQ_ST_ACK)
      else $error("waitrequest low outside the ack cycle");

   a_wait_idle: assert property ((state_q == UIRQ_ST_IDLE && !req) |=> avs_waitrequest)
      else $error("waitrequest low without a request");

   a_commit_ack: assert property (commit_wr |-> !avs_waitrequest)
      else $error("write landed while waitrequest high");

   a_wr_once: assert property (commit_wr |=> !commit_wr)
      else $error("write landed twice");

   // read data must not drift between the capture and the ack edge
   a_rdata_hold: assert property (!(state_q == UIRQ_ST_IDLE && avs_read) |=>
      $stable(avs_readdata))
      else $error("read data moved without a read");

   a_ctrl_write: assert property ((commit_wr && avs_address == `UIRQ_OFS_CTRL &&
      avs_byteenable[0]) |=> core_irq_select == $past(avs_writedata[`UIRQ_SEL_BIT]))
      else $error("control bit not written");

   a_ctrl_rdback: assert property ((state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_CTRL) |-> avs_readdata == $past(ctrl_q))
      else $error("control read mismatch");

   a_src_rdback: assert property ((state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_SRC) |-> avs_readdata == $past(bus.src))
      else $error("source status read mismatch");

   a_ctrl_rsv: assert property (ctrl_q[31:1] == 31'h00000000)
      else $error("reserved control bit set");

   a_mask_rsv: assert property ((bus.msk & ~VALID) == 32'h00000000)
      else $error("mask bit outside its fields");

   a_sw_set: assert property ((commit_wr && avs_address == `UIRQ_OFS_SRC_SET) |=>
      ((bus.src & $past(wdata_m)) == $past(wdata_m)))
      else $error("software source set lost");

   // an event racing its own acknowledge must not be lost
   a_set_wins: assert property (s_clr_wr |=>
      ((bus.src & $past(hw_set)) == $past(hw_set)))
      else $error("clear beat a hardware event");

   a_src_quiet: assert property ((!commit_wr && hw_set == 32'h00000000) |=>
      $stable(bus.src))
      else $error("source changed without event or write");

   a_mset_no_src: assert property ((commit_wr && hw_set == 32'h00000000 &&
      avs_address == `UIRQ_OFS_MSK_SET) |=> $stable(bus.src))
      else $error("mask write touched a source");

   a_msk_idle: assert property (!commit_wr |=> $stable(bus.msk))
      else $error("mask changed without a write");

   c_clear: cover property (s_clr_wr ##1 !irq);
   c_mask_set: cover property (s_mset_wr ##[1:4] irq);
   c_set_vs_clr: cover property (s_clr_wr and (|(hw_set & wdata_m)));
   c_unmapped: cover property (state_q == UIRQ_ST_ACK && avs_address == 6'h3C);
   c_rdback: cover property (state_q == UIRQ_ST_ACK && avs_read &&
      avs_address == `UIRQ_OFS_SRC_CLR);

endmodule

// [uirq_core_model.sv]
// model of the usb core side: pulses the event pins of the interrupt wrapper
module uirq_core_model
   import uirq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        fire,
   input  wire logic [31:0] ev,
   output logic      [7:0]  core_general_irq,
   output logic             bus_power_drive_irq,
   output logic      [3:0]  rx_endpoint_irq,
   output logic      [3:0]  tx_endpoint_irq,
   output logic             control_endpoint_irq
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // event pulses
   // one cycle per request; lines rest low between events, so a level never looks sticky
   always_ff @(posedge clk) begin
      core_general_irq     <= fire ? ev[23:16] : 8'h00;
      bus_power_drive_irq  <= fire ? ev[24] : 1'b0;
      rx_endpoint_irq      <= fire ? ev[12:9] : 4'h0;
      tx_endpoint_irq      <= fire ? ev[4:1] : 4'h0;
      control_endpoint_irq <= fire ? ev[0] : 1'b0;
   end
endmodule

// [tb_top.sv]
// self-checking bench for the usb interrupt acknowledge and mask wrapper
`include "uirq_map.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import uirq_pkg::*;

   logic        clk;
   logic        rstn;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  core_general_irq;
   logic        bus_power_drive_irq;
   logic [3:0]  rx_endpoint_irq;
   logic [3:0]  tx_endpoint_irq;
   logic        control_endpoint_irq;
   logic        core_irq_select;
   logic        irq;
   logic        fire;
   logic [31:0] ev;
   logic [31:0] fld [4] = '{32'h01FF0000, 32'h00001E00, 32'h0000001E, 32'h00000001};
   int          errors = 0;
   int          n_compared = 0;

   uirq_top uirq_top_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_general_irq(core_general_irq),
      .bus_power_drive_irq(bus_power_drive_irq), .rx_endpoint_irq(rx_endpoint_irq),
      .tx_endpoint_irq(tx_endpoint_irq), .control_endpoint_irq(control_endpoint_irq),
      .core_irq_select(core_irq_select), .irq(irq));

   uirq_core_model uirq_core_model_i (.clk(clk), .fire(fire), .ev(ev),
      .core_general_irq(core_general_irq), .bus_power_drive_irq(bus_power_drive_irq),
      .rx_endpoint_irq(rx_endpoint_irq), .tx_endpoint_irq(tx_endpoint_irq),
      .control_endpoint_irq(control_endpoint_irq));

   // ==========================================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #(40 * 5000);
      errors++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run();
   end

   // ==========================================================
   // shared tasks
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s: got %h want %h", $time, msg, got, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge; only the watchdog ends a wait
   task automatic bus_acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_acc(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] q;
      bus_acc(1'b0, a, 32'h00000000, q);
      chk(q, exp, msg);
   endtask

   // core pulse seen at one edge, latched by the wrapper at the next
   task automatic fire_ev(input logic [31:0] w);
      @(posedge clk);
      fire <= 1'b1;
      ev   <= w;
      @(posedge clk);
      fire <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(`UIRQ_OFS_CTRL, 32'h00000000, "control after reset");
      rd_chk(`UIRQ_OFS_SRC_CLR, 32'h00000000, "source after reset");
      rd_chk(`UIRQ_OFS_MSK, 32'h00000000, "mask after reset");
      rd_chk(`UIRQ_OFS_MASKED, 32'h00000000, "masked after reset");
      chk({31'h0, irq}, 32'h00000000, "irq after reset");
      $display("test reset done");
   endtask

   task automatic t_mask();
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m = m | fld[i];
         wr(`UIRQ_OFS_MSK_SET, fld[i]);
         rd_chk(`UIRQ_OFS_MSK, m, "mask field set");
      end
      rd_chk(`UIRQ_OFS_MSK_SET, `UIRQ_VALID, "mask set readback");
      wr(`UIRQ_OFS_MSK, 32'h00000000);
      rd_chk(`UIRQ_OFS_MSK, `UIRQ_VALID, "direct mask write");
      wr(`UIRQ_OFS_MSK_SET, 32'h00000000);
      rd_chk(`UIRQ_OFS_MSK, `UIRQ_VALID, "zero mask set");
      wr(`UIRQ_OFS_MSK_CLR, 32'h00010001);
      rd_chk(`UIRQ_OFS_MSK_CLR, 32'h01FE1E1E, "mask clear bits");
      wr(`UIRQ_OFS_MSK_CLR, 32'hFFFFFFFF);
      wr(`UIRQ_OFS_MSK_SET, 32'hFE00E1E0);
      rd_chk(`UIRQ_OFS_MSK, 32'h00000000, "reserved mask bits");
      $display("test mask done");
   endtask

   task automatic t_source();
      logic [31:0] m;
      m = `UIRQ_VALID;
      fire_ev(32'hFFFFFFFF);
      rd_chk(`UIRQ_OFS_SRC_CLR, m, "raw sources with masks off");
      chk({31'h0, irq}, 32'h00000000, "irq with masks off");
      wr(`UIRQ_OFS_SRC_CLR, 32'h00000000);
      rd_chk(`UIRQ_OFS_SRC, m, "zero clear write");
      for (int i = 0; i < 4; i++) begin
         m = m & ~fld[i];
         wr(`UIRQ_OFS_SRC_CLR, fld[i]);
         rd_chk(`UIRQ_OFS_SRC_CLR, m, "source field cleared");
      end
      fire_ev(32'h01000000);
      rd_chk(`UIRQ_OFS_SRC, 32'h01000000, "power drive bit");
      wr(`UIRQ_OFS_SRC_CLR, 32'h01000000);
      fire_ev(32'h00010000);
      rd_chk(`UIRQ_OFS_SRC, 32'h00010000, "general event bit");
      wr(`UIRQ_OFS_SRC_CLR, 32'h00010000);
      $display("test source done");
   endtask

   task automatic t_irq();
      wr(`UIRQ_OFS_MSK_SET, 32'h00000001);
      fire_ev(32'h00000003);
      rd_chk(`UIRQ_OFS_MASKED, 32'h00000001, "masked status");
      chk({31'h0, irq}, 32'h00000001, "irq with enabled source");
      wr(`UIRQ_OFS_SRC_CLR, 32'h00000001);
      rd_chk(`UIRQ_OFS_SRC, 32'h00000002, "unmasked source kept");
      chk({31'h0, irq}, 32'h00000000, "irq after clear");
      wr(`UIRQ_OFS_SRC_CLR, 32'h00000002);
      wr(`UIRQ_OFS_CTRL, 32'h00000001);
      rd_chk(`UIRQ_OFS_CTRL, 32'h00000001, "control readback");
      chk({31'h0, core_irq_select}, 32'h00000001, "select bit set");
      wr(`UIRQ_OFS_CTRL, 32'h00000000);
      rd_chk(6'h3C, 32'h00000000, "unmapped read");
      $display("test irq done");
   endtask

   task automatic t_set();
      wr(`UIRQ_OFS_SRC_SET, 32'hFFFFFFFF);
      rd_chk(`UIRQ_OFS_SRC_SET, `UIRQ_VALID, "software source set");
      wr(`UIRQ_OFS_SRC, 32'h00000000);
      wr(`UIRQ_OFS_MASKED, 32'h00000000);
      rd_chk(`UIRQ_OFS_SRC, `UIRQ_VALID, "status writes ignored");
      wr(`UIRQ_OFS_SRC_CLR, 32'hFFFFFFFF);
      rd_chk(`UIRQ_OFS_SRC, 32'h00000000, "all sources cleared");
      avs_byteenable <= 4'hE;
      wr(`UIRQ_OFS_CTRL, 32'h00000001);
      avs_byteenable <= 4'hF;
      rd_chk(`UIRQ_OFS_CTRL, 32'h00000000, "control with lane 0 off");
      $display("test set done");
   endtask

   // reset in mid run with a pending enabled source and the select bit up
   task automatic t_rerst();
      wr(`UIRQ_OFS_MSK_SET, `UIRQ_VALID);
      fire_ev(32'h00000200);
      wr(`UIRQ_OFS_CTRL, 32'h00000001);
      chk({31'h0, irq}, 32'h00000001, "irq before reset");
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      chk({avs_waitrequest, core_irq_select, 29'h0, irq}, 32'h80000000, "outputs in reset");
      rd_chk(`UIRQ_OFS_SRC, 32'h00000000, "source after mid reset");
      rd_chk(`UIRQ_OFS_MSK, 32'h00000000, "mask after mid reset");
      rd_chk(`UIRQ_OFS_CTRL, 32'h00000000, "control after mid reset");
      $display("test mid reset done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rstn           = 1'b0;
      avs_address    = 6'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h00000000;
      avs_byteenable = 4'hF;
      fire           = 1'b0;
      ev             = 32'h00000000;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_mask();
      t_source();
      t_set();
      t_irq();
      t_rerst();
      complete_run();
   end
endmodule
